// ---- common/cable_detect_defines.svh ----
// register offsets, field positions, reset values and timing counts
// assumes an 8-bit register port and a 40 MHz clock
`ifndef CABLE_DETECT_DEFINES_SVH
`define CABLE_DETECT_DEFINES_SVH

// =====================================================
// register offsets
`define ADDR_MANUAL_LEVEL 8'h20
`define ADDR_RESET_CTRL 8'h48
`define ADDR_FILTER_CTRL 8'h56
`define ADDR_RAW_B 8'h6a
`define ADDR_HOTPLUG_CTRL 8'h6c
`define ADDR_RAW_A 8'h6f

// =====================================================
// field positions
`define BIT_MANUAL_LEVEL_A 7
`define BIT_MANUAL_LEVEL_B 6
`define BIT_RESET_DISABLE 6
`define BIT_FILTER_DISABLE 7
`define BIT_RAW_B 7
`define BIT_RAW_A 0
`define BIT_MANUAL_SELECT 0

// =====================================================
// reset values
`define RST_MANUAL_LEVEL 1'b1
`define RST_RESET_DISABLE 1'b0
`define RST_FILTER_DISABLE 1'b0
`define RST_FILTER_DURATION 7'h58
`define RST_MANUAL_SELECT 1'b0
`define RST_AUTO_POLICY 2'h1
`define RST_ASSERT_DELAY 4'ha

// =====================================================
// timing
`define CLK_FREQ_KHZ 40000
`define FILTER_UNIT_CYCLES 2
`define HOTPLUG_STEP_MS 100
`define HOTPLUG_STEP_CYCLES (`HOTPLUG_STEP_MS * `CLK_FREQ_KHZ)

`endif

// ---- common/cable_detect_pkg.sv ----
// types shared by the cable detect and hot-plug logic
// assumes nothing of its surroundings
package cable_detect_pkg;

  // automatic hot-plug policies
  typedef enum logic [1:0] {
    POLICY_EDID = 2'h0,
    POLICY_DELAYED_CABLE = 2'h1,
    POLICY_EDID_CABLE = 2'h2,
    POLICY_EDID_CABLE_MANUAL = 2'h3
  } hotplug_policy_t;

endpackage

// ---- verilog/deglitch_filter.sv ----
// one port's +5 V deglitch filter
// assumes level_in is already synchronised to clk
`include "cable_detect_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module deglitch_filter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level_in,
  input wire logic bypass,
  input wire logic [6:0] duration,
  output logic filt_out
);

  logic prev_q;
  logic tick_q;
  logic [6:0] count_q;
  logic [6:0] count_d;
  wire change = level_in ^ prev_q;
  wire count_step = tick_q && (count_q < duration);

  // =====================================================
  // qualification count, one unit per two clock cycles
  assign count_d = (change || !level_in) ? 7'h00 : (count_step ? count_q + 7'h01 : count_q);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 1'b0;
      tick_q <= 1'b0;
      count_q <= 7'h00;
      filt_out <= 1'b0;
    end else begin
      prev_q <= level_in;
      tick_q <= ~tick_q;
      count_q <= count_d;
      filt_out <= bypass ? level_in : (level_in && !change && count_q >= duration);
    end
  end

  // =====================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  filter_drop_a: assert property (change && !bypass |=> !filt_out)
    else $error("filter output stayed high after input change");
  filter_qualify_a: assert property ($rose(filt_out) && !$past(bypass) |-> $past(count_q) >= $past(duration))
    else $error("filter rose before full duration");
  filter_bypass_a: assert property (bypass |=> filt_out == $past(level_in))
    else $error("bypassed filter does not follow input");
  unit_tick_a: assert property (tick_q |=> !tick_q ##1 tick_q)
    else $error("filter unit is not two clock cycles");
  filter_rise_c: cover property (!bypass ##1 $rose(filt_out));

endmodule
`default_nettype wire

// ---- verilog/hotplug_policy.sv ----
// one port's hot-plug delay timer and policy selection
// assumes all inputs come from logic on clk
`timescale 1ns/1ps
`default_nettype none

module hotplug_policy #(
  parameter int unsigned STEP_CYCLES = 32'd4000000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic filt_det,
  input wire logic raw_det,
  input wire logic edid_active,
  input wire logic manual_sel,
  input wire logic manual_level,
  input wire cable_detect_pkg::hotplug_policy_t policy,
  input wire logic [3:0] delay,
  output logic asserted_q
);

  logic [31:0] cyc_q;
  logic [3:0] steps_q;
  logic auto_level;
  wire timer_in = (policy == cable_detect_pkg::POLICY_DELAYED_CABLE) ? filt_det : raw_det;
  wire delayed = timer_in && (steps_q >= delay);
  wire step_end = (cyc_q == STEP_CYCLES - 32'd1);

  // =====================================================
  // delay timer, 100 ms per step, cleared by cable loss
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc_q <= 32'h0;
      steps_q <= 4'h0;
    end else if (!timer_in) begin
      cyc_q <= 32'h0;
      steps_q <= 4'h0;
    end else if (steps_q < delay) begin
      cyc_q <= step_end ? 32'h0 : cyc_q + 32'h1;
      steps_q <= step_end ? steps_q + 4'h1 : steps_q;
    end
  end

  // =====================================================
  // automatic policy, ignored in manual mode
  always_comb begin
    unique case (policy)
      cable_detect_pkg::POLICY_EDID: auto_level = edid_active;
      cable_detect_pkg::POLICY_DELAYED_CABLE: auto_level = delayed;
      cable_detect_pkg::POLICY_EDID_CABLE: auto_level = edid_active && delayed;
      cable_detect_pkg::POLICY_EDID_CABLE_MANUAL: auto_level = edid_active && delayed && manual_level;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      asserted_q <= 1'b0;
    end else begin
      asserted_q <= manual_sel ? manual_level : auto_level;
    end
  end

  // =====================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  manual_follow_a: assert property (manual_sel |=> asserted_q == $past(manual_level))
    else $error("manual mode does not follow manual level");
  edid_policy_a: assert property (!manual_sel && policy == cable_detect_pkg::POLICY_EDID
      |=> asserted_q == $past(edid_active))
    else $error("edid policy mismatch");
  cable_removal_a: assert property (!manual_sel && !filt_det
      && policy == cable_detect_pkg::POLICY_DELAYED_CABLE |=> !asserted_q)
    else $error("hot-plug not dropped on cable removal");
  edid_cable_a: assert property (!manual_sel && policy == cable_detect_pkg::POLICY_EDID_CABLE
      && (!edid_active || !raw_det) |=> !asserted_q)
    else $error("hot-plug held without edid and cable");
  manual_gate_a: assert property (!manual_sel && policy == cable_detect_pkg::POLICY_EDID_CABLE_MANUAL
      && !manual_level |=> !asserted_q)
    else $error("hot-plug held with manual level low");
  // the rise was decided one cycle back, so mode and policy are taken from then
  delay_done_a: assert property ($rose(asserted_q) && !$past(manual_sel)
      && $past(policy) != cable_detect_pkg::POLICY_EDID |-> $past(steps_q) >= $past(delay))
    else $error("hot-plug asserted before delay elapsed");
  delayed_assert_c: cover property (!manual_sel && policy == cable_detect_pkg::POLICY_DELAYED_CABLE
      ##1 $rose(asserted_q));

endmodule
`default_nettype wire

// ---- verilog/cable_detect_hotplug_ctrl.sv ----
// cable presence sensing, deglitch filtering, receiver reset and hot-plug drive for two ports
// assumes a synchronous 8-bit register port on clk; cable power pins are asynchronous
`include "cable_detect_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cable_detect_hotplug_ctrl #(
  parameter int unsigned HOTPLUG_STEP_CYCLES = `HOTPLUG_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic cable_power_in_a,
  input wire logic cable_power_in_b,
  input wire logic edid_active_a,
  input wire logic edid_active_b,
  input wire logic rx_port_sel,
  output logic cable_detect_flag_a,
  output logic cable_detect_flag_b,
  output logic rx_section_reset,
  output logic hotplug_out_a_o,
  output logic hotplug_out_a_oe,
  output logic hotplug_out_b_o,
  output logic hotplug_out_b_oe
);

  // =====================================================
  // declarations
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic hotplug_manual_level_a_q;
  logic hotplug_manual_level_b_q;
  logic cable_reset_disable_q;
  logic deglitch_filter_disable_q;
  logic [6:0] deglitch_filter_duration_q;
  logic hotplug_manual_select_q;
  cable_detect_pkg::hotplug_policy_t hotplug_auto_policy_q;
  logic [3:0] hotplug_assert_delay_q;
  logic [7:0] rdata_d;
  logic filt_a;
  logic filt_b;
  logic hp_asserted_a;
  logic hp_asserted_b;
  logic rx_section_reset_d;

  // =====================================================
  // raw presence, two-flop synchroniser per pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= {cable_power_in_b, cable_power_in_a};
      pin_sync_q <= pin_meta_q;
    end
  end

  wire cable_present_raw_a = pin_sync_q[0];
  wire cable_present_raw_b = pin_sync_q[1];

  // =====================================================
  // register decode
  wire sel_manual_level = (reg_addr == `ADDR_MANUAL_LEVEL);
  wire sel_reset_ctrl = (reg_addr == `ADDR_RESET_CTRL);
  wire sel_filter_ctrl = (reg_addr == `ADDR_FILTER_CTRL);
  wire sel_raw_b = (reg_addr == `ADDR_RAW_B);
  wire sel_hotplug_ctrl = (reg_addr == `ADDR_HOTPLUG_CTRL);
  wire sel_raw_a = (reg_addr == `ADDR_RAW_A);

  wire wr_manual_level = reg_wr && sel_manual_level;
  wire wr_reset_ctrl = reg_wr && sel_reset_ctrl;
  wire wr_filter_ctrl = reg_wr && sel_filter_ctrl;
  wire wr_hotplug_ctrl = reg_wr && sel_hotplug_ctrl;

  // =====================================================
  // manual hot-plug levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hotplug_manual_level_a_q <= `RST_MANUAL_LEVEL;
      hotplug_manual_level_b_q <= `RST_MANUAL_LEVEL;
    end else if (wr_manual_level) begin
      hotplug_manual_level_a_q <= reg_wdata[`BIT_MANUAL_LEVEL_A];
      hotplug_manual_level_b_q <= reg_wdata[`BIT_MANUAL_LEVEL_B];
    end
  end

  // =====================================================
  // cable reset disable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cable_reset_disable_q <= `RST_RESET_DISABLE;
    end else if (wr_reset_ctrl) begin
      cable_reset_disable_q <= reg_wdata[`BIT_RESET_DISABLE];
    end
  end

  // =====================================================
  // deglitch filter control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      deglitch_filter_disable_q <= `RST_FILTER_DISABLE;
      deglitch_filter_duration_q <= `RST_FILTER_DURATION;
    end else if (wr_filter_ctrl) begin
      deglitch_filter_disable_q <= reg_wdata[`BIT_FILTER_DISABLE];
      deglitch_filter_duration_q <= reg_wdata[6:0];
    end
  end

  // =====================================================
  // hot-plug control: delay, policy, manual select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hotplug_assert_delay_q <= `RST_ASSERT_DELAY;
      hotplug_auto_policy_q <= cable_detect_pkg::hotplug_policy_t'(`RST_AUTO_POLICY);
      hotplug_manual_select_q <= `RST_MANUAL_SELECT;
    end else if (wr_hotplug_ctrl) begin
      hotplug_assert_delay_q <= reg_wdata[7:4];
      hotplug_auto_policy_q <= cable_detect_pkg::hotplug_policy_t'(reg_wdata[2:1]);
      hotplug_manual_select_q <= reg_wdata[`BIT_MANUAL_SELECT];
    end
  end

  // =====================================================
  // read-back mux, unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    if (sel_manual_level) begin
      rdata_d[`BIT_MANUAL_LEVEL_A] = hotplug_manual_level_a_q;
      rdata_d[`BIT_MANUAL_LEVEL_B] = hotplug_manual_level_b_q;
    end
    if (sel_reset_ctrl) begin
      rdata_d[`BIT_RESET_DISABLE] = cable_reset_disable_q;
    end
    if (sel_filter_ctrl) begin
      rdata_d = {deglitch_filter_disable_q, deglitch_filter_duration_q};
    end
    if (sel_raw_b) begin
      rdata_d[`BIT_RAW_B] = cable_present_raw_b;
    end
    if (sel_hotplug_ctrl) begin
      rdata_d = {hotplug_assert_delay_q, 1'b0, hotplug_auto_policy_q, hotplug_manual_select_q};
    end
    if (sel_raw_a) begin
      rdata_d[`BIT_RAW_A] = cable_present_raw_a;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // =====================================================
  // per-port deglitch filters on the free-running clock
  deglitch_filter filter_a (
    .clk(clk),
    .resetn(resetn),
    .level_in(cable_present_raw_a),
    .bypass(deglitch_filter_disable_q),
    .duration(deglitch_filter_duration_q),
    .filt_out(filt_a)
  );

  deglitch_filter filter_b (
    .clk(clk),
    .resetn(resetn),
    .level_in(cable_present_raw_b),
    .bypass(deglitch_filter_disable_q),
    .duration(deglitch_filter_duration_q),
    .filt_out(filt_b)
  );

  // filtered detect drives the cable-detect flags
  assign cable_detect_flag_a = filt_a;
  assign cable_detect_flag_b = filt_b;

  // =====================================================
  // receiver section reset from the selected port
  assign rx_section_reset_d = !cable_reset_disable_q && !(rx_port_sel ? filt_b : filt_a);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_section_reset <= 1'b1;
    end else begin
      rx_section_reset <= rx_section_reset_d;
    end
  end

  // =====================================================
  // per-port hot-plug policy
  hotplug_policy #(
    .STEP_CYCLES(HOTPLUG_STEP_CYCLES)
  ) policy_a (
    .clk(clk),
    .resetn(resetn),
    .filt_det(filt_a),
    .raw_det(cable_present_raw_a),
    .edid_active(edid_active_a),
    .manual_sel(hotplug_manual_select_q),
    .manual_level(hotplug_manual_level_a_q),
    .policy(hotplug_auto_policy_q),
    .delay(hotplug_assert_delay_q),
    .asserted_q(hp_asserted_a)
  );

  hotplug_policy #(
    .STEP_CYCLES(HOTPLUG_STEP_CYCLES)
  ) policy_b (
    .clk(clk),
    .resetn(resetn),
    .filt_det(filt_b),
    .raw_det(cable_present_raw_b),
    .edid_active(edid_active_b),
    .manual_sel(hotplug_manual_select_q),
    .manual_level(hotplug_manual_level_b_q),
    .policy(hotplug_auto_policy_q),
    .delay(hotplug_assert_delay_q),
    .asserted_q(hp_asserted_b)
  );

  // =====================================================
  // open-drain pins: drive low to deassert, release to assert
  assign hotplug_out_a_o = 1'b0;
  assign hotplug_out_b_o = 1'b0;
  assign hotplug_out_a_oe = !hp_asserted_a;
  assign hotplug_out_b_oe = !hp_asserted_b;

  // =====================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  raw_a_read_a: assert property (sel_raw_a |=> reg_rdata == {7'h00, $past(pin_sync_q[0])})
    else $error("raw presence A read-back wrong");
  raw_b_read_a: assert property (sel_raw_b |=> reg_rdata == {$past(pin_sync_q[1]), 7'h00})
    else $error("raw presence B read-back wrong");
  pin_latency_a: assert property (pin_sync_q[0] != $past(pin_sync_q[0])
      |-> pin_sync_q[0] == $past(cable_power_in_a, 2))
    else $error("raw presence A not two cycles behind pin");
  cable_reset_a: assert property (!cable_reset_disable_q && !(rx_port_sel ? filt_b : filt_a)
      |=> rx_section_reset)
    else $error("receiver not held in reset without cable");
  reset_off_a: assert property (cable_reset_disable_q |=> !rx_section_reset)
    else $error("receiver reset while cable reset disabled");
  // a set flag needs presence on the raw pin one cycle earlier
  flag_source_a: assert property (cable_detect_flag_a == filt_a && cable_detect_flag_b == filt_b
      && (!cable_detect_flag_a || $past(pin_sync_q[0])) && (!cable_detect_flag_b || $past(pin_sync_q[1])))
    else $error("cable flags not from filtered detect");
  open_drain_a: assert property (!hotplug_out_a_o && !hotplug_out_b_o
      && hotplug_out_a_oe == !hp_asserted_a && hotplug_out_b_oe == !hp_asserted_b)
    else $error("hot-plug pin not open drain");
  manual_pin_a: assert property (hotplug_manual_select_q && !hotplug_manual_level_a_q |=> hotplug_out_a_oe)
    else $error("manual level zero does not pull port A low");
  // manual mode must already hold a cycle back, else the switch itself moves the pin
  policy_ignored_a: assert property (hotplug_manual_select_q && $past(hotplug_manual_select_q)
      && $stable(hotplug_manual_level_b_q) && $changed(hotplug_auto_policy_q) |=> $stable(hp_asserted_b))
    else $error("policy change affected manual output");

  reset_release_c: cover property ($fell(rx_section_reset));
  manual_mode_c: cover property (hotplug_manual_select_q ##1 $fell(hotplug_out_b_oe));
  filter_bypass_c: cover property (deglitch_filter_disable_q && $rose(filt_a));

endmodule
`default_nettype wire

// ---- bench/cable_source.sv ----
// cable source model: +5 V drive and hot-plug wires with pull-up
// assumes the bench sets plug levels shortly after clk rises
`timescale 1ns/1ps
`default_nettype none

module cable_source (
  input wire logic plug_a,
  input wire logic plug_b,
  input wire logic hp_a_o,
  input wire logic hp_a_oe,
  input wire logic hp_b_o,
  input wire logic hp_b_oe,
  output logic power_a,
  output logic power_b,
  output logic hp_a,
  output logic hp_b
);
  // ==========
  // cable power follows the plug state
  assign power_a = plug_a;
  assign power_b = plug_b;
  // pull-up sets the level while a pin is released
  assign hp_a = hp_a_oe ? hp_a_o : 1'b1;
  assign hp_b = hp_b_oe ? hp_b_o : 1'b1;
endmodule

`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the cable detect and hot-plug block
// assumes a hot-plug step shortened to 4 clocks
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic pa = 1'b0;
  logic pb = 1'b0;
  logic ea = 1'b0;
  logic eb = 1'b0;
  logic sel = 1'b0;
  logic fa, fb, rr, hao, haoe, hbo, hboe, pwa, pwb, hotplug_out, hpb;
  int miscompares = 0;
  int total_checks = 0;

  // ==========
  // clock and instances
  always #12.5 clk = ~clk;

  cable_detect_hotplug_ctrl #(.HOTPLUG_STEP_CYCLES(4)) u_dut (
    .clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata),
    .cable_power_in_a(pwa), .cable_power_in_b(pwb), .edid_active_a(ea), .edid_active_b(eb),
    .rx_port_sel(sel), .cable_detect_flag_a(fa), .cable_detect_flag_b(fb), .rx_section_reset(rr),
    .hotplug_out_a_o(hao), .hotplug_out_a_oe(haoe), .hotplug_out_b_o(hbo), .hotplug_out_b_oe(hboe)
  );

  cable_source u_src (
    .plug_a(pa), .plug_b(pb), .hp_a_o(hao), .hp_a_oe(haoe), .hp_b_o(hbo), .hp_b_oe(hboe),
    .power_a(pwa), .power_b(pwb), .hp_a(hotplug_out), .hp_b(hpb)
  );

  // ==========
  // helpers
  function automatic logic mon(input int i);
    case (i)
      0: mon = fa;
      1: mon = fb;
      2: mon = rr;
      3: mon = hotplug_out;
      default: mon = hpb;
    endcase
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    miscompares++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask

  // read one register and compare the byte
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1;
    addr = a;
    @(posedge clk);
    #1;
    total_checks++;
    if (rdata !== e) fail($sformatf("register %h read %h", a, rdata));
  endtask

  // signal keeps level v for n cycles
  task automatic chk_hold(input int i, input logic v, input int n);
    bit bad;
    bad = 0;
    total_checks++;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (mon(i) !== v) bad = 1;
    end
    if (bad) fail($sformatf("signal %0d left level %b", i, v));
  endtask

  // signal reaches level v within n cycles
  task automatic chk_reach(input int i, input logic v, input int n);
    int k;
    k = 0;
    total_checks++;
    while (mon(i) !== v && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (mon(i) !== v) begin
      fail($sformatf("signal %0d never reached %b", i, v));
      close_out();
    end
  endtask

  // ==========
  // scenarios
  task automatic t_reset();
    logic [7:0] ad [7];
    logic [7:0] ex [7];
    ad = '{8'h20, 8'h48, 8'h56, 8'h6a, 8'h6c, 8'h6f, 8'h00};
    ex = '{8'hc0, 8'h00, 8'h58, 8'h00, 8'ha2, 8'h00, 8'h00};
    for (int j = 0; j < 7; j++) begin
      chk_reg(ad[j], ex[j]);
    end
    wreg(8'h6f, 8'hff);
    chk_reg(8'h6f, 8'h00);
    chk_hold(2, 1'b1, 2);
    chk_hold(3, 1'b0, 2);
    $display("done reset values");
  endtask

  task automatic t_filter();
    wreg(8'h56, 8'h05);
    pa = 1'b1;
    chk_hold(0, 1'b0, 9);
    chk_reach(0, 1'b1, 12);
    pa = 1'b0;
    chk_reach(0, 1'b0, 5);
    pa = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    pa = 1'b0;
    @(posedge clk);
    #1;
    pa = 1'b1;
    chk_hold(0, 1'b0, 9);
    chk_reach(0, 1'b1, 12);
    pa = 1'b0;
    chk_reach(0, 1'b0, 5);
    wreg(8'h56, 8'h85);
    pa = 1'b1;
    chk_reach(0, 1'b1, 4);
    pa = 1'b0;
    chk_reach(0, 1'b0, 4);
    wreg(8'h56, 8'h05);
    $display("done deglitch filter");
  endtask

  task automatic t_port_b();
    pb = 1'b1;
    chk_reach(1, 1'b1, 25);
    chk_hold(0, 1'b0, 1);
    chk_reg(8'h6a, 8'h80);
    chk_reg(8'h6f, 8'h00);
    pb = 1'b0;
    chk_reach(1, 1'b0, 5);
    $display("done port b");
  endtask

  task automatic t_rx_reset();
    pa = 1'b1;
    chk_reach(0, 1'b1, 25);
    chk_reach(2, 1'b0, 3);
    chk_reg(8'h6f, 8'h01);
    sel = 1'b1;
    chk_reach(2, 1'b1, 3);
    wreg(8'h48, 8'h40);
    chk_reach(2, 1'b0, 3);
    wreg(8'h48, 8'h00);
    chk_reach(2, 1'b1, 3);
    sel = 1'b0;
    pa = 1'b0;
    chk_reach(0, 1'b0, 5);
    $display("done receiver reset");
  endtask

  task automatic t_manual();
    wreg(8'h6c, 8'h07);
    wreg(8'h20, 8'h80);
    chk_reach(3, 1'b1, 3);
    chk_reach(4, 1'b0, 3);
    wreg(8'h20, 8'h40);
    chk_reach(3, 1'b0, 3);
    chk_reach(4, 1'b1, 3);
    wreg(8'h20, 8'hc0);
    $display("done manual drive");
  endtask

  task automatic t_edid();
    wreg(8'h6c, 8'h00);
    chk_reach(3, 1'b0, 3);
    ea = 1'b1;
    chk_reach(3, 1'b1, 3);
    chk_hold(4, 1'b0, 2);
    ea = 1'b0;
    chk_reach(3, 1'b0, 3);
    $display("done edid policy");
  endtask

  task automatic t_delay();
    wreg(8'h6c, 8'h22);
    pa = 1'b1;
    chk_reach(0, 1'b1, 25);
    chk_hold(3, 1'b0, 7);
    chk_reach(3, 1'b1, 4);
    pa = 1'b0;
    chk_reach(3, 1'b0, 6);
    $display("done delayed cable policy");
  endtask

  task automatic t_raw_edid();
    wreg(8'h6c, 8'h14);
    ea = 1'b1;
    pa = 1'b1;
    chk_hold(3, 1'b0, 6);
    chk_reach(3, 1'b1, 4);
    ea = 1'b0;
    chk_reach(3, 1'b0, 3);
    chk_hold(3, 1'b0, 12);
    ea = 1'b1;
    chk_reach(3, 1'b1, 6);
    pa = 1'b0;
    chk_reach(3, 1'b0, 5);
    ea = 1'b0;
    $display("done edid and cable policy");
  endtask

  task automatic t_three();
    wreg(8'h20, 8'h40);
    wreg(8'h6c, 8'h06);
    ea = 1'b1;
    pa = 1'b1;
    chk_hold(3, 1'b0, 10);
    wreg(8'h20, 8'hc0);
    chk_reach(3, 1'b1, 3);
    chk_hold(4, 1'b0, 1);
    wreg(8'h20, 8'h40);
    chk_reach(3, 1'b0, 3);
    pa = 1'b0;
    ea = 1'b0;
    $display("done three-condition policy");
  endtask

  // ==========
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_filter();
    t_port_b();
    t_rx_reset();
    t_manual();
    t_edid();
    t_delay();
    t_raw_edid();
    t_three();
    close_out();
  end
endmodule

`default_nettype wire
